// File: hw/fault_led_reporter.sv
/*
 * Power-up self-test fault reporter: builds the error word, shows it
 * for the display and as decimal for the remote bus, and walks the
 * four service LEDs through the fault codes after power-up.
 * Assumes the test engine and register master run on mclk.
 */
// Decided for this implementation: the plain strobed port and the address map.
// Functional notes
// - Several failures give one word, the OR of their weights.
// - Each failure class owns one fixed bit of the error word.
// - Serial bus bit set when fitted hardware fails to answer.
// - Miscellaneous bit set when expected hardware is absent.
// - LED codes only after power-up runs; dark for other runs.
// - No fault: all LEDs on ten seconds with beep, then off.
// - Fault: all LEDs on four seconds before any code.
// - After all-on, blink the type code of one failure bit.
// - Type code blinks at the rapid rate.
// - Two four-bit detail codes follow the type code.
// - Detail codes blink slowly or stay steady, never rapid.
// - Repeat type and details for each failure until the last.
// - Patterns binary, LED 0 lowest; type n means weight 2**n.
// - ROM details 1,1 main ROM; 1,2 boot ROM.
// - First RAM details 1,1 memory board; 1,2 controller board.
// - Second RAM details 1,1 or 1,2 both memory board RAM.
// - Control interface details 1,1 port 9; 1,2 port 10.
// - Remote query runs the test; word read back in decimal.
// - Power-up failure shows the error word in hexadecimal.
`timescale 1ns/1ns
module fault_led_reporter
    import selftest_pkg::*;
#(
    parameter int MS_CYC = CLK_HZ / MS_PER_S  // Cycles per millisecond
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Register port
    input  wire bus_req_t   breq,
    output logic [31:0]     rdata,
    // Self-test engine
    input  wire logic       gpib_tst,
    output logic            run_req,
    output src_t            run_src,
    input  wire logic       test_done,
    input  wire res_t       res,
    input  wire logic [7:0] bus_fitted,
    input  wire logic [7:0] bus_ok,
    input  wire logic [7:0] hw_expect,
    input  wire logic [7:0] hw_present,
    input  wire det_t       bus_det,
    input  wire det_t       misc_det,
    // Indicators and results
    output logic [3:0]      led,
    output logic            beep,
    output logic [15:0]     disp_word,
    output logic            disp_fail,
    output logic [15:0]     gpib_dec,
    output logic            gpib_rdy
);

    localparam int PW = $clog2(MS_CYC);
    localparam logic [PW-1:0] PS_LAST = PW'(MS_CYC - 1);
    localparam logic [3:0]    LAST_IDX = 4'(NCLS);
    localparam logic [3:0]    DD_LAST  = 4'(NCLS);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ALLON, ST_SCAN, ST_TYPE, ST_DET1, ST_DET2
    } st_t;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    st_t          st_r;
    logic [PW-1:0] ps_r;
    logic         tick_r;
    logic         busy_r, pwr_pend_r, run_req_r, gpib_rdy_r;
    src_t         src_r;
    logic [15:0]  err_r, disp_word_r, dec_r;
    logic         disp_fail_r, beep_r, pass_r;
    logic [3:0]   led_r, idx_r;
    logic [15:0]  cnt_r, bcnt_r, rapid_r, slow_r, dwell_r;
    logic         phase_r;
    det_t         det_r [1:NCLS];
    logic [12:0]  bin_r;
    logic [15:0]  bcd_r;
    logic [3:0]   dd_cnt_r;
    logic         dd_run_r, dd_gpib_r;
    logic [31:0]  rdata_r;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire logic wr_ctrl  = breq.wr && (breq.addr == REG_CTRL);
    wire logic wr_rapid = breq.wr && (breq.addr == REG_RAPID);
    wire logic wr_slow  = breq.wr && (breq.addr == REG_SLOW);
    wire logic wr_dwell = breq.wr && (breq.addr == REG_DWELL);
    wire logic prog_go  = wr_ctrl && breq.wdata[CTRL_PROG];
    wire logic diag_go  = wr_ctrl && breq.wdata[CTRL_DIAG];
    wire logic led_idle = (st_r == ST_IDLE);
    wire logic [31:0] stat_w = {27'h0, !led_idle, gpib_rdy_r,
                                pwr_pend_r, busy_r, disp_fail_r};
    logic [31:0] rsel;

    // Unmapped offsets read as zero
    always_comb begin
        if (breq.addr == REG_ERR)        rsel = {16'h0, err_r};
        else if (breq.addr == REG_DEC)   rsel = {16'h0, dec_r};
        else if (breq.addr == REG_STAT)  rsel = stat_w;
        else if (breq.addr == REG_RAPID) rsel = {16'h0, rapid_r};
        else if (breq.addr == REG_SLOW)  rsel = {16'h0, slow_r};
        else if (breq.addr == REG_DWELL) rsel = {16'h0, dwell_r};
        else                             rsel = 32'h0;
    end

    // ------------------------------------------------------------
    // Error word assembly
    // ------------------------------------------------------------
    wire logic bus_fail  = |(bus_fitted & ~bus_ok);
    wire logic misc_fail = |(hw_expect & ~hw_present);
    logic [15:0] part_w [0:NCLS];
    det_t        det_w  [1:NCLS];
    assign part_w[0] = 16'h0;

    // One weight and one detail pair per failure class
    genvar c;
    generate
        for (c = 1; c <= NCLS; c++) begin : g_cls
            logic hit;
            if (c == CLS_BUS) begin : g_bus
                assign hit = bus_fail;
                assign det_w[c] = bus_det;
            end else if (c == CLS_MISC) begin : g_misc
                assign hit = misc_fail;
                assign det_w[c] = misc_det;
            end else begin : g_raw
                assign hit = res.fail[c];
                if (c == CLS_ROM) begin : g_rom
                    assign det_w[c] = {DET_ONE,
                        res.rom_boot ? DET_TWO : DET_ONE};
                end else if (c == CLS_RAM1) begin : g_ram1
                    assign det_w[c] = {DET_ONE,
                        res.ram1_ctrl ? DET_TWO : DET_ONE};
                end else if (c == CLS_RAM2) begin : g_ram2
                    assign det_w[c] = {DET_ONE,
                        res.ram2_alt ? DET_TWO : DET_ONE};
                end else if (c == CLS_PORT) begin : g_port
                    assign det_w[c] = {DET_ONE,
                        res.port10 ? DET_TWO : DET_ONE};
                end else begin : g_none
                    assign det_w[c] = {LED_OFF, LED_OFF};
                end
            end
            // Sum of weights is their OR since bits never overlap
            assign part_w[c] = part_w[c-1] |
                               (hit ? WEIGHT[c] : 16'h0);
            always_ff @(posedge mclk) begin
                if (!rstn)
                    det_r[c] <= {LED_OFF, LED_OFF};
                else if (test_done && busy_r)
                    det_r[c] <= det_w[c];
            end
        end
    endgenerate
    wire logic [15:0] err_nxt = part_w[NCLS];

    // ------------------------------------------------------------
    // Millisecond prescaler
    // ------------------------------------------------------------
    // Every blink and dwell figure counts these ticks
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ps_r   <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (ps_r == PS_LAST);
            ps_r   <= (ps_r == PS_LAST) ? '0 : ps_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Run control and tunables
    // ------------------------------------------------------------
    // Requests arriving while a run or LED walk is active are dropped;
    // the power-up run is owed from reset and taken first.
    wire logic can_run = !busy_r && led_idle && !dd_run_r;
    wire logic any_go  = pwr_pend_r || gpib_tst || prog_go || diag_go;
    src_t src_sel;
    assign src_sel = pwr_pend_r ? SRC_POWER :
                     gpib_tst   ? SRC_GPIB  :
                     prog_go    ? SRC_PROG  : SRC_DIAG;
    wire logic done_ok = test_done && busy_r;
    wire logic pwr_done = done_ok && (src_r == SRC_POWER);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            busy_r     <= 1'b0;
            pwr_pend_r <= 1'b1;
            run_req_r  <= 1'b0;
            src_r      <= SRC_POWER;
            err_r      <= 16'h0;
        end else begin
            run_req_r <= can_run && any_go;
            if (can_run && any_go) begin
                busy_r     <= 1'b1;
                pwr_pend_r <= 1'b0;
                src_r      <= src_sel;
            end else if (done_ok) begin
                busy_r <= 1'b0;
                err_r  <= err_nxt;
            end
        end
    end

    // Software-tuned blink and dwell lengths
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rapid_r <= RAPID_DEF;
            slow_r  <= SLOW_DEF;
            dwell_r <= DWELL_DEF;
        end else begin
            if (wr_rapid) rapid_r <= breq.wdata[15:0];
            if (wr_slow)  slow_r  <= breq.wdata[15:0];
            if (wr_dwell) dwell_r <= breq.wdata[15:0];
        end
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rstn)
            rdata_r <= 32'h0;
        else
            rdata_r <= breq.rd ? rsel : 32'h0;
    end

    // ------------------------------------------------------------
    // Display word
    // ------------------------------------------------------------
    // Only the power-up run posts the failure message
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            disp_word_r <= 16'h0;
            disp_fail_r <= 1'b0;
        end else if (pwr_done) begin
            disp_word_r <= err_nxt;
            disp_fail_r <= (err_nxt != 16'h0);
        end
    end

    // ------------------------------------------------------------
    // Binary to decimal for the remote reply
    // ------------------------------------------------------------
    logic [15:0] bcd_adj;
    genvar d;
    generate
        for (d = 0; d < 4; d++) begin : g_dig
            wire logic [3:0] dig = bcd_r[4*d +: 4];
            assign bcd_adj[4*d +: 4] = (dig > 4'h4) ? dig + 4'h3 : dig;
        end
    endgenerate

    // Shift-add-3, one bit a cycle; the reply flag rises when done after a remote run
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bin_r      <= 13'h0;
            bcd_r      <= 16'h0;
            dd_cnt_r   <= 4'h0;
            dd_run_r   <= 1'b0;
            dd_gpib_r  <= 1'b0;
            dec_r      <= 16'h0;
            gpib_rdy_r <= 1'b0;
        end else if (done_ok) begin
            bin_r      <= err_nxt[12:0];
            bcd_r      <= 16'h0;
            dd_cnt_r   <= 4'h0;
            dd_run_r   <= 1'b1;
            dd_gpib_r  <= (src_r == SRC_GPIB);
            if (src_r == SRC_GPIB) gpib_rdy_r <= 1'b0;
        end else if (dd_run_r) begin
            bcd_r    <= {bcd_adj[14:0], bin_r[12]};
            bin_r    <= {bin_r[11:0], 1'b0};
            dd_cnt_r <= dd_cnt_r + 4'h1;
            if (dd_cnt_r == DD_LAST) begin
                dd_run_r   <= 1'b0;
                dec_r      <= {bcd_adj[14:0], bin_r[12]};
                gpib_rdy_r <= gpib_rdy_r | dd_gpib_r;
            end
        end else if (gpib_tst && can_run) begin
            gpib_rdy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // LED sequencer
    // ------------------------------------------------------------
    wire logic  cnt_end  = tick_r && (cnt_r == 16'h1);
    wire logic  is_type  = (st_r == ST_TYPE);
    wire logic [15:0] per = is_type ? rapid_r : slow_r;
    wire logic  steady   = !is_type && (slow_r == 16'h0);
    wire logic  bl_end   = tick_r && (bcnt_r <= 16'h1);
    logic [3:0] pat;
    logic [3:0] led_nxt;

    // Pattern for the showing state; LED 0 is the lowest bit
    always_comb begin
        case (st_r)
            ST_TYPE: pat = idx_r;
            ST_DET1: pat = det_r[idx_r].d1;
            ST_DET2: pat = det_r[idx_r].d2;
            default: pat = LED_OFF;
        endcase
        if (st_r == ST_ALLON)
            led_nxt = LED_ALL;
        else if (phase_r || steady)
            led_nxt = pat;
        else
            led_nxt = LED_OFF;
    end

    // Walk: all-on, then type and two details per set bit
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_r    <= ST_IDLE;
            idx_r   <= 4'h1;
            cnt_r   <= 16'h0;
            bcnt_r  <= 16'h0;
            phase_r <= 1'b1;
            pass_r  <= 1'b0;
        end else begin
            if (tick_r && cnt_r != 16'h0)
                cnt_r <= cnt_r - 16'h1;
            if (bl_end) begin
                bcnt_r  <= per;
                phase_r <= !phase_r;
            end else if (tick_r) begin
                bcnt_r <= bcnt_r - 16'h1;
            end
            case (st_r)
                ST_IDLE: begin
                    if (pwr_done) begin
                        st_r   <= ST_ALLON;
                        idx_r  <= 4'h1;
                        pass_r <= (err_nxt == 16'h0);
                        cnt_r  <= (err_nxt == 16'h0) ? PASS_MS
                                                     : FAULT_MS;
                    end
                end
                ST_ALLON: begin
                    if (cnt_end)
                        st_r <= pass_r ? ST_IDLE : ST_SCAN;
                end
                ST_SCAN: begin
                    if (err_r[idx_r]) begin
                        st_r    <= ST_TYPE;
                        cnt_r   <= dwell_r;
                        bcnt_r  <= rapid_r;
                        phase_r <= 1'b1;
                    end else if (idx_r == LAST_IDX) begin
                        st_r <= ST_IDLE;
                    end else begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                ST_TYPE, ST_DET1: begin
                    if (cnt_end) begin
                        st_r    <= is_type ? ST_DET1 : ST_DET2;
                        cnt_r   <= dwell_r;
                        bcnt_r  <= slow_r;
                        phase_r <= 1'b1;
                    end
                end
                ST_DET2: begin
                    if (cnt_end) begin
                        if (idx_r == LAST_IDX) begin
                            st_r <= ST_IDLE;
                        end else begin
                            st_r  <= ST_SCAN;
                            idx_r <= idx_r + 4'h1;
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Beep runs only in the first part of a clean all-on interval
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            led_r  <= LED_OFF;
            beep_r <= 1'b0;
        end else begin
            led_r  <= led_nxt;
            beep_r <= (st_r == ST_ALLON) && pass_r &&
                      (cnt_r > BEEP_END);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata     = rdata_r;
    assign run_req   = run_req_r;
    assign run_src   = src_r;
    assign led       = led_r;
    assign beep      = beep_r;
    assign disp_word = disp_word_r;
    assign disp_fail = disp_fail_r;
    assign gpib_dec  = dec_r;
    assign gpib_rdy  = gpib_rdy_r;

endmodule : fault_led_reporter

// File: common/selftest_pkg.sv
/*
 * Shared constants and carriers for the power-up fault reporter.
 * Assumes a 10 MHz system clock; times are given in their own unit
 * and converted to ticks or cycles where they are used.
 */
package selftest_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_HZ   = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int PASS_S   = 10;          // All-on time, no fault
    localparam int FAULT_S  = 4;           // All-on time before codes
    localparam int BEEP_MS  = 200;         // Short beep length
    localparam logic [15:0] PASS_MS  = 16'(PASS_S * MS_PER_S);
    localparam logic [15:0] FAULT_MS = 16'(FAULT_S * MS_PER_S);
    localparam logic [15:0] BEEP_END = 16'(PASS_S * MS_PER_S - BEEP_MS);

    // Blink and dwell defaults in milliseconds (tunable at run time)
    localparam logic [15:0] RAPID_DEF = 16'h0064;
    localparam logic [15:0] SLOW_DEF  = 16'h01f4;
    localparam logic [15:0] DWELL_DEF = 16'h0bb8;

    // ------------------------------------------------------------
    // Failure classes: class n owns weight 2**n
    // ------------------------------------------------------------
    localparam int NCLS     = 12;
    localparam int CLS_ROM  = 2;
    localparam int CLS_RAM1 = 3;
    localparam int CLS_RAM2 = 4;
    localparam int CLS_PORT = 8;
    localparam int CLS_BUS  = 9;
    localparam int CLS_MISC = 12;
    localparam logic [15:0] WEIGHT [1:NCLS] = '{
        16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040,
        16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000};
    localparam logic [3:0] DET_ONE = 4'h1;
    localparam logic [3:0] DET_TWO = 4'h2;
    localparam logic [3:0] LED_ALL = 4'hf;
    localparam logic [3:0] LED_OFF = 4'h0;

    // ------------------------------------------------------------
    // Register map (byte offsets) and control bits
    // ------------------------------------------------------------
    localparam logic [7:0] REG_ERR   = 8'h00;
    localparam logic [7:0] REG_DEC   = 8'h04;
    localparam logic [7:0] REG_STAT  = 8'h08;
    localparam logic [7:0] REG_CTRL  = 8'h0c;
    localparam logic [7:0] REG_RAPID = 8'h10;
    localparam logic [7:0] REG_SLOW  = 8'h14;
    localparam logic [7:0] REG_DWELL = 8'h18;
    localparam int CTRL_PROG = 0;
    localparam int CTRL_DIAG = 1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SRC_POWER, SRC_GPIB, SRC_PROG, SRC_DIAG} src_t;

    typedef struct packed {
        logic [NCLS:1] fail;       // Raw class failures from the tests
        logic          rom_boot;   // ROM fault is in boot ROM
        logic          ram1_ctrl;  // First RAM fault is controller RAM
        logic          ram2_alt;   // Second RAM fault, alternate area
        logic          port10;     // Control interface fault on port 10
    } res_t;

    typedef struct packed {
        logic [3:0] d1;
        logic [3:0] d2;
    } det_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

endpackage : selftest_pkg

// File: test/test_engine_model.sv
/*
 * Self-test engine model: done pulse a set delay after run_req.
 * Assumes res_cfg and dly are set before the request.
 */
`timescale 1ns/1ns
module test_engine_model
    import selftest_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Stimulus
    input  wire logic       run_req,
    input  wire res_t       res_cfg,
    input  wire logic [7:0] dly,
    // Results
    output logic            test_done,
    output res_t            res
);
    logic [7:0] cnt_r;

    // Flags held until the next run
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_r     <= 8'h00;
            test_done <= 1'b0;
            res       <= '0;
        end else begin
            test_done <= (cnt_r == 8'h01);
            if (run_req) begin
                cnt_r <= dly;
                res   <= res_cfg;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule : test_engine_model

// File: test/fault_led_assertions.sv
/*
 * Checker bound to the fault reporter's ports.
 * Assumes one clock mclk and synchronous low reset rstn.
 */
`timescale 1ns/1ns
module fault_led_checker
    import selftest_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // Requests
    input wire bus_req_t    breq,
    input wire logic        gpib_tst,
    input wire logic        run_req,
    input wire src_t        run_src,
    // Test results
    input wire logic        test_done,
    input wire res_t        res,
    input wire logic [7:0]  bus_fitted,
    input wire logic [7:0]  bus_ok,
    input wire logic [7:0]  hw_expect,
    input wire logic [7:0]  hw_present,
    // Indicators
    input wire logic [3:0]  led,
    input wire logic        beep,
    input wire logic [15:0] disp_word,
    input wire logic        disp_fail,
    input wire logic        gpib_rdy
);
    // Classes 9 and 12 come from bus and hw checks
    wire logic [15:0] exp_w = {3'h0, |(hw_expect & ~hw_present),
        res.fail[11:10], |(bus_fitted & ~bus_ok), res.fail[8:1], 1'b0};
    wire logic pwr_done = test_done && run_src == SRC_POWER;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    boot_run_a: assert property (
        $rose(rstn) |=> run_req && run_src == SRC_POWER)
        else $error("no power-up run");
    err_word_a: assert property (
        pwr_done |-> ##[1:2] disp_word == exp_w)
        else $error("error word wrong");
    fail_flag_a: assert property (
        pwr_done |-> ##[1:2] disp_fail == (exp_w != 16'h0))
        else $error("fail flag wrong");
    dark_other_a: assert property (
        run_src != SRC_POWER |-> led == LED_OFF && !beep)
        else $error("lamps lit off power-up");
    all_on_a: assert property (
        pwr_done |-> ##2 (led == LED_ALL) [*8])
        else $error("lamps not all on");
    beep_pass_a: assert property (
        beep |-> led == LED_ALL && run_src == SRC_POWER)
        else $error("stray beep");
    dec_ready_a: assert property (
        $rose(gpib_rdy) |-> $past(test_done, 14) && run_src == SRC_GPIB)
        else $error("remote answer mistimed");
    gpib_cause_a: assert property (
        run_req && run_src == SRC_GPIB |-> $past(gpib_tst))
        else $error("remote run unasked");
    prog_cause_a: assert property (
        run_req && run_src == SRC_PROG |->
            $past(breq.wr) && $past(breq.addr) == REG_CTRL)
        else $error("program run unasked");
endmodule : fault_led_checker

bind fault_led_reporter fault_led_checker chk (.mclk, .rstn, .breq,
    .gpib_tst, .run_req, .run_src, .test_done, .res, .bus_fitted, .bus_ok,
    .hw_expect, .hw_present, .led, .beep, .disp_word, .disp_fail, .gpib_rdy);

// File: test/tb_top.sv
/*
 * Bench: pass walk, two-fault walk, then random non-power-up runs.
 * Assumes MS_CYC of 4: one millisecond is four cycles.
 */
`timescale 1ns/1ns
module tb_top
    import selftest_pkg::*;
;
    typedef struct {string nm; logic [31:0] v;} note_t;
    logic        mclk, rstn, gpib_tst, run_req, test_done, beep, look;
    logic        disp_fail, gpib_rdy, rd_d;
    bus_req_t    breq;
    logic [31:0] rdata;
    src_t        run_src;
    res_t        res, cfg;
    det_t        bus_det, misc_det;
    logic [7:0]  bus_fitted, bus_ok, hw_expect, hw_present, dly;
    logic [3:0]  led;
    logic [15:0] disp_word, gpib_dec, e;
    int          err_count, compares, cyc, base, seed, o;
    note_t       q[$];

    fault_led_reporter #(.MS_CYC(4)) dut (.mclk, .rstn, .breq, .rdata,
        .gpib_tst, .run_req, .run_src, .test_done, .res, .bus_fitted,
        .bus_ok, .hw_expect, .hw_present, .bus_det, .misc_det, .led, .beep,
        .disp_word, .disp_fail, .gpib_dec, .gpib_rdy);
    test_engine_model eng (.mclk, .rstn, .run_req, .res_cfg(cfg), .dly,
        .test_done, .res);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] bcd(input logic [15:0] w);
        int v;
        v = w;
        bcd = 32'h0;
        for (int i = 0; i < 4; i++) begin
            bcd[4*i +: 4] = 4'(v % 10);
            v = v / 10;
        end
    endfunction : bcd
    task automatic chk(input logic [31:0] s);
        note_t n;
        n = q.pop_front();
        compares++;
        if (s !== n.v) begin
            $display("unexpected %s: expected %h, seen %h", n.nm, n.v, s);
            err_count++;
        end
    endtask : chk
    // Strobe, then one idle cycle
    task automatic bus(input logic [7:0] a, input logic [31:0] d,
                       input logic w);
        breq <= '{a, d, w, ~w};
        @(posedge mclk);
        breq <= '0;
        @(posedge mclk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
        q.push_back('{nm, x});
        bus(a, 32'h0, 1'b0);
    endtask : rd
    task automatic at(input int t, input logic [4:0] x, input string nm);
        while (cyc < base + t) @(posedge mclk);
        q.push_back('{nm, 32'(x)});
        look <= 1'b1;
        @(posedge mclk);
        look <= 1'b0;
    endtask : at
    task automatic wait_done;
        int i;
        for (i = 0; i < 300 && test_done !== 1'b1; i++) @(posedge mclk);
        if (i == 300) err_count++;
        base = cyc;
    endtask : wait_done
    task automatic end_of_test;
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Read data stand one cycle after rd
    always @(posedge mclk) begin
        rd_d <= breq.rd;
        cyc <= cyc + 1;
        if (rd_d) chk(rdata);
        if (look) chk({27'h0, beep, led});
    end
    initial begin
        repeat (70000) @(posedge mclk);
        err_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, gpib_tst, look, rd_d, breq, cfg} = '0;
        {err_count, compares, cyc, base} = '0;
        seed = 32'h3e2f7d9f;
        dly = 8'd40;
        {bus_fitted, bus_ok, hw_expect, hw_present} = 32'h0f0f0303;
        bus_det = '{4'h5, 4'ha};
        misc_det = '{4'h3, 4'hc};
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd(REG_RAPID, 32'h64, "rapid default");
        wait_done();
        rd(REG_ERR, 32'h0, "pass word");
        at(100, 5'h1f, "pass lamps");
        at(39000, 5'h0f, "pass lamps");
        at(40100, 5'h00, "pass end");
        // Boot ROM and bus faults; raw class 12 ignored
        cfg <= '{fail: 12'h802, rom_boot: 1'b1, default: 1'b0};
        bus_ok <= 8'h0e;
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        bus(REG_RAPID, 32'd8, 1'b1);
        bus(REG_SLOW, 32'd24, 1'b1);
        bus(REG_DWELL, 32'd96, 1'b1);
        wait_done();
        rd(REG_ERR, 32'h0204, "fault word");
        at(15900, 5'h0f, "all on");
        for (int k = 0; k < 2; k++) begin
            o = 16002 + 1152 * k;
            at(o + 16, k ? 5'h09 : 5'h02, "type");
            at(o + 48, 5'h00, "type off");
            at(o + 432, k ? 5'h05 : 5'h01, "detail 1");
            at(o + 816, k ? 5'h0a : 5'h02, "detail 2");
        end
        at(18406, 5'h00, "walk end");
        // Remote, program, diagnostic runs
        for (int k = 0; k < 3; k++) begin
            cfg <= 16'($random(seed));
            bus_ok <= 8'($random(seed));
            hw_present <= 8'($random(seed));
            dly <= 8'($random(seed) & 31) + 8'h01;
            @(posedge mclk);
            if (k == 0) begin
                gpib_tst <= 1'b1;
                @(posedge mclk);
                gpib_tst <= 1'b0;
            end else begin
                bus(REG_CTRL, 32'(k), 1'b1);
            end
            wait_done();
            at(5, 5'h00, "lamps dark");
            repeat (12) @(posedge mclk);
            e = {3'h0, |(hw_expect & ~hw_present), cfg.fail[11:10],
                 |(bus_fitted & ~bus_ok), cfg.fail[8:1], 1'b0};
            q.push_back('{"gpib_dec", bcd(e)});
            chk({16'h0, gpib_dec});
            rd(REG_ERR, 32'(e), "word");
            rd(REG_DEC, bcd(e), "decimal");
        end
        rd(8'h40, 32'h0, "unmapped");
        end_of_test();
    end
endmodule : tb_top
